// *** load_pkg.sv ***
// Constants, encodings and types for the narrow load decode and execute block
package load_pkg;
	localparam logic [4:0] NAR_IMM_OP = 5'h11;
	localparam logic [6:0] NAR_REG_OP = 7'h2d;
	localparam logic [11:0] EXCL_OP = 12'he8d;
	localparam logic [11:0] WIMM_OP = 12'hf8b;
	localparam logic [11:0] WVAR_OP = 12'hf83;
	localparam logic [11:0] LIT_OP = 12'hf83;
	localparam logic [3:0] EXCL_B_SUB = 4'h4;
	localparam logic [3:0] EXCL_H_SUB = 4'h5;
	localparam logic [3:0] REG_SP = 4'hd;
	localparam logic [3:0] REG_PC = 4'hf;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_HALF = 2'h2;
	localparam logic [31:0] PC_ALIGN_MASK = 32'hfffffffc;
	localparam logic [31:0] WORD_ZERO = 32'h0;
	// Instruction classes after decode
	typedef enum logic [2:0] {
		kind_none = 3'h0,
		kind_excl = 3'h1,
		kind_load = 3'h2,
		kind_literal = 3'h3,
		kind_hint = 3'h4,
		kind_undef = 3'h5,
		kind_unpriv = 3'h6
	} kind_t;
	// Execute sequence, Gray coded
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_regs = 2'b01,
		st_access = 2'b11,
		st_write = 2'b10
	} state_t;
endpackage : load_pkg

// *** decode_if.sv ***
// Decoded instruction fields passed from the field decoder to the core
`timescale 1ns/1ps
interface decode_if;
	logic [31:0] instr;
	logic wide;
	load_pkg::kind_t kind;
	logic [3:0] base;
	logic [3:0] target;
	logic [3:0] offs;
	logic [11:0] imm;
	logic [1:0] shift;
	logic [1:0] size;
	logic add;
	logic index;
	logic wback;
	logic use_reg;
	logic unpred;
	modport dec (input instr, input wide, output kind, output base, output target, output offs,
		output imm, output shift, output size, output add, output index, output wback,
		output use_reg, output unpred);
	modport core (output instr, output wide, input kind, input base, input target, input offs,
		input imm, input shift, input size, input add, input index, input wback,
		input use_reg, input unpred);
endinterface : decode_if

// *** field_decoder.sv ***
// Combinational field decoder for the narrow load group
`timescale 1ns/1ps
module field_decoder (
	decode_if.dec d
);
	logic [15:0] h1;
	logic [15:0] h2;
	logic [15:0] hn;
	assign h1 = d.instr[31:16];
	assign h2 = d.instr[15:0];
	assign hn = d.instr[15:0];

	// Classify and extract fields
	always_comb begin
		d.kind = load_pkg::kind_none;
		d.base = h1[3:0];
		d.target = h2[15:12];
		d.offs = h2[3:0];
		d.imm = 12'h0;
		d.shift = 2'h0;
		d.size = load_pkg::SIZE_HALF;
		d.add = 1'b1;
		d.index = 1'b1;
		d.wback = 1'b0;
		d.use_reg = 1'b0;
		d.unpred = 1'b0;
		if (!d.wide) begin
			d.base = {1'b0, hn[5:3]};
			d.target = {1'b0, hn[2:0]};
			d.offs = {1'b0, hn[8:6]};
			if (hn[15:11] == load_pkg::NAR_IMM_OP) begin
				d.kind = load_pkg::kind_load;
				d.imm = {6'h0, hn[10:6], 1'b0};
			end else if (hn[15:9] == load_pkg::NAR_REG_OP) begin
				d.kind = load_pkg::kind_load;
				d.use_reg = 1'b1;
			end
		end else if (h1[15:4] == load_pkg::EXCL_OP
				&& (h2[7:4] == load_pkg::EXCL_B_SUB || h2[7:4] == load_pkg::EXCL_H_SUB)) begin
			d.kind = load_pkg::kind_excl;
			d.size = (h2[7:4] == load_pkg::EXCL_B_SUB) ? load_pkg::SIZE_BYTE : load_pkg::SIZE_HALF;
			d.unpred = (d.target == load_pkg::REG_SP) || (d.target == load_pkg::REG_PC)
				|| (d.base == load_pkg::REG_PC);
		end else if ((h1[15:4] == load_pkg::WIMM_OP || h1[15:4] == load_pkg::LIT_OP)
				&& h1[3:0] == load_pkg::REG_PC) begin
			d.kind = (d.target == load_pkg::REG_PC) ? load_pkg::kind_hint : load_pkg::kind_literal;
			d.add = h1[7];
			d.imm = h2[11:0];
		end else if (h1[15:4] == load_pkg::WIMM_OP) begin
			d.kind = (d.target == load_pkg::REG_PC) ? load_pkg::kind_hint : load_pkg::kind_load;
			d.imm = h2[11:0];
			d.unpred = (d.target == load_pkg::REG_SP);
		end else if (h1[15:4] == load_pkg::WVAR_OP && h2[11]) begin
			d.imm = {4'h0, h2[7:0]};
			d.index = h2[10];
			d.add = h2[9];
			d.wback = h2[8];
			if (d.target == load_pkg::REG_PC && h2[10:8] == 3'b100)
				d.kind = load_pkg::kind_hint;
			else if (h2[10:8] == 3'b110)
				d.kind = load_pkg::kind_unpriv;
			else if (!h2[10] && !h2[8])
				d.kind = load_pkg::kind_undef;
			else
				d.kind = load_pkg::kind_load;
			d.unpred = (d.target == load_pkg::REG_SP) || (d.target == load_pkg::REG_PC && h2[8])
				|| (h2[8] && d.base == d.target);
		end else if (h1[15:4] == load_pkg::WVAR_OP && h2[11:6] == 6'h0) begin
			d.kind = (d.target == load_pkg::REG_PC) ? load_pkg::kind_hint : load_pkg::kind_load;
			d.use_reg = 1'b1;
			d.shift = h2[5:4];
			d.unpred = (d.target == load_pkg::REG_SP) || (d.offs == load_pkg::REG_SP)
				|| (d.offs == load_pkg::REG_PC);
		end
	end
endmodule : field_decoder

// *** halfword_byte_load_decode.sv ***
// Decode and execute of exclusive byte/halfword and halfword loads
`timescale 1ns/1ps
module halfword_byte_load_decode (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic instr_wide,
	input wire logic cond_pass,
	input wire logic [31:0] pc_value,
	output logic instr_ready,
	output logic [3:0] rf_raddr_a,
	output logic [3:0] rf_raddr_b,
	input wire logic [31:0] rf_rdata_a,
	input wire logic [31:0] rf_rdata_b,
	output logic mem_req,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic mem_excl,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_shareable,
	output logic mon_local_set,
	output logic mon_global_mark,
	output logic [31:0] mon_addr,
	output logic [1:0] mon_size,
	output logic rf_we_target,
	output logic [3:0] rf_waddr_target,
	output logic [31:0] rf_wdata_target,
	output logic rf_we_base,
	output logic [3:0] rf_waddr_base,
	output logic [31:0] rf_wdata_base,
	output logic done,
	output logic undef_trap,
	output logic unpred_flag,
	output logic unpriv_redirect,
	output logic not_handled
);
	decode_if dif ();
	assign dif.instr = instr;
	assign dif.wide = instr_wide;

	field_decoder u_dec (
		.d(dif.dec)
	);

	load_pkg::state_t state_q;
	logic ready_q;
	logic take;
	logic [3:0] base_q;
	logic [3:0] target_q;
	logic [11:0] imm_q;
	logic [1:0] shift_q;
	logic [1:0] size_q;
	logic add_q;
	logic index_q;
	logic wback_q;
	logic use_reg_q;
	logic excl_q;
	logic literal_q;
	logic [31:0] pc_q;
	logic [31:0] base_val;
	logic [31:0] off_val;
	logic [31:0] offset_addr;
	logic [31:0] access_addr;
	logic [31:0] wb_addr_q;
	logic [31:0] load_data;
	logic executes;
	logic mem_req_q;
	logic [31:0] mem_addr_q;
	logic mem_excl_q;
	logic mon_local_q;
	logic mon_global_q;
	logic rf_we_t_q;
	logic [31:0] rf_wd_t_q;
	logic rf_we_b_q;
	logic done_q;
	logic undef_q;
	logic unpred_q;
	logic unpriv_q;
	logic foreign_q;

	// Instruction taken when offered while idle
	assign take = instr_valid && ready_q;
	// Only real loads that pass the condition and are predictable go on to memory
	assign executes = cond_pass && !dif.unpred
		&& (dif.kind == load_pkg::kind_load || dif.kind == load_pkg::kind_excl
		|| dif.kind == load_pkg::kind_literal);

	// Address arithmetic from register data returned in st_regs
	assign base_val = literal_q ? (pc_q & load_pkg::PC_ALIGN_MASK) : rf_rdata_a;
	assign off_val = use_reg_q ? (rf_rdata_b << shift_q) : {20'h0, imm_q};
	assign offset_addr = add_q ? (base_val + off_val) : (base_val - off_val);
	assign access_addr = index_q ? offset_addr : base_val;
	// Zero extension of the returned byte or halfword
	assign load_data = (size_q == load_pkg::SIZE_BYTE) ? {24'h0, mem_rdata[7:0]} : {16'h0, mem_rdata};

	// Sequence state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= load_pkg::st_idle;
		end else begin
			unique case (state_q)
				load_pkg::st_idle: if (take && executes) state_q <= load_pkg::st_regs;
				load_pkg::st_regs: state_q <= load_pkg::st_access;
				load_pkg::st_access: if (mem_ack) state_q <= load_pkg::st_write;
				load_pkg::st_write: state_q <= load_pkg::st_idle;
			endcase
		end
	end

	// Ready only in idle, dropped the cycle after a load is taken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_q <= 1'b0;
		end else if (state_q == load_pkg::st_idle) begin
			ready_q <= !(take && executes);
		end else begin
			ready_q <= (state_q == load_pkg::st_write);
		end
	end

	// Latch decoded fields when a load is taken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			base_q <= 4'h0;
			target_q <= 4'h0;
			imm_q <= 12'h0;
			shift_q <= 2'h0;
			size_q <= load_pkg::SIZE_HALF;
			add_q <= 1'b1;
			index_q <= 1'b1;
			wback_q <= 1'b0;
			use_reg_q <= 1'b0;
			excl_q <= 1'b0;
			literal_q <= 1'b0;
			pc_q <= load_pkg::WORD_ZERO;
		end else if (take && executes) begin
			base_q <= dif.base;
			target_q <= dif.target;
			imm_q <= dif.imm;
			shift_q <= dif.shift;
			size_q <= dif.size;
			add_q <= dif.add;
			index_q <= dif.index || (dif.kind == load_pkg::kind_excl);
			wback_q <= dif.wback && (dif.kind == load_pkg::kind_load);
			use_reg_q <= dif.use_reg;
			excl_q <= (dif.kind == load_pkg::kind_excl);
			literal_q <= (dif.kind == load_pkg::kind_literal);
			pc_q <= pc_value;
		end
	end

	// Register read addresses, held from the take onward
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rf_raddr_a <= 4'h0;
			rf_raddr_b <= 4'h0;
		end else if (take && executes) begin
			rf_raddr_a <= dif.base;
			rf_raddr_b <= dif.offs;
		end
	end

	// Memory request; exclusive loads use the bare base with no offset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_req_q <= 1'b0;
			mem_addr_q <= load_pkg::WORD_ZERO;
			mem_excl_q <= 1'b0;
		end else if (state_q == load_pkg::st_regs) begin
			mem_req_q <= 1'b1;
			mem_addr_q <= excl_q ? base_val : access_addr;
			mem_excl_q <= excl_q;
		end else if (state_q == load_pkg::st_access && mem_ack) begin
			mem_req_q <= 1'b0;
			mem_excl_q <= 1'b0;
		end
	end

	// Write-back address kept for the base update after the access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_addr_q <= load_pkg::WORD_ZERO;
		end else if (state_q == load_pkg::st_regs) begin
			wb_addr_q <= offset_addr;
		end
	end

	// Exclusive monitor pulses on completion of the access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_local_q <= 1'b0;
			mon_global_q <= 1'b0;
		end else begin
			mon_local_q <= state_q == load_pkg::st_access && mem_ack && excl_q;
			mon_global_q <= state_q == load_pkg::st_access && mem_ack && excl_q && mem_shareable;
		end
	end

	// Monitor address and size, held after each exclusive access
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_addr <= load_pkg::WORD_ZERO;
			mon_size <= load_pkg::SIZE_HALF;
		end else if (state_q == load_pkg::st_access && mem_ack && excl_q) begin
			mon_addr <= mem_addr_q;
			mon_size <= size_q;
		end
	end

	// Target register write of the zero-extended load data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rf_we_t_q <= 1'b0;
			rf_wd_t_q <= load_pkg::WORD_ZERO;
			rf_waddr_target <= 4'h0;
		end else begin
			rf_we_t_q <= 1'b0;
			if (state_q == load_pkg::st_access && mem_ack) begin
				rf_we_t_q <= 1'b1;
				rf_wd_t_q <= load_data;
				rf_waddr_target <= target_q;
			end
		end
	end

	// Base register write-back, same cycle as the target write
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rf_we_b_q <= 1'b0;
			rf_wdata_base <= load_pkg::WORD_ZERO;
			rf_waddr_base <= 4'h0;
		end else begin
			rf_we_b_q <= 1'b0;
			if (state_q == load_pkg::st_access && mem_ack) begin
				rf_we_b_q <= wback_q;
				rf_wdata_base <= wb_addr_q;
				rf_waddr_base <= base_q;
			end
		end
	end

	// Completion pulse, for loads and for instructions with no effect
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (state_q == load_pkg::st_access && mem_ack) || (take && !executes);
		end
	end

	// Undefined encoding pulse
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			undef_q <= 1'b0;
		end else begin
			undef_q <= take && cond_pass && (dif.kind == load_pkg::kind_undef);
		end
	end

	// Unpredictable register choice pulse
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			unpred_q <= 1'b0;
		end else begin
			unpred_q <= take && cond_pass && dif.unpred;
		end
	end

	// Redirect pulse for the unprivileged form
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			unpriv_q <= 1'b0;
		end else begin
			unpriv_q <= take && (dif.kind == load_pkg::kind_unpriv);
		end
	end

	// Pulse for instructions outside this group
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			foreign_q <= 1'b0;
		end else begin
			foreign_q <= take && (dif.kind == load_pkg::kind_none);
		end
	end

	// Outputs
	assign instr_ready = ready_q;
	assign mem_req = mem_req_q;
	assign mem_addr = mem_addr_q;
	assign mem_size = size_q;
	assign mem_excl = mem_excl_q;
	assign mon_local_set = mon_local_q;
	assign mon_global_mark = mon_global_q;
	assign rf_we_target = rf_we_t_q;
	assign rf_wdata_target = rf_wd_t_q;
	assign rf_we_base = rf_we_b_q;
	assign done = done_q;
	assign undef_trap = undef_q;
	assign unpred_flag = unpred_q;
	assign unpriv_redirect = unpriv_q;
	assign not_handled = foreign_q;
endmodule : halfword_byte_load_decode

// *** load_check_sva.sv ***
// Port-level checks of the narrow load block
`timescale 1ns/1ps
module load_check (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic cond_pass,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [1:0] mem_size,
	input wire logic mem_excl,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_shareable,
	input wire logic mon_local_set,
	input wire logic mon_global_mark,
	input wire logic [31:0] mon_addr,
	input wire logic [1:0] mon_size,
	input wire logic rf_we_target,
	input wire logic [31:0] rf_wdata_target,
	input wire logic rf_we_base,
	input wire logic done,
	input wire logic unpred_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Finished memory access, plain or exclusive
	sequence ack_s;
		mem_req && mem_ack;
	endsequence
	sequence excl_ack_s;
		mem_req && mem_ack && mem_excl;
	endsequence
	req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_size))
		else $error("request changed before ack");
	req_drop_a: assert property (ack_s |=> !mem_req && done)
		else $error("request not closed after ack");
	excl_mon_a: assert property (excl_ack_s |=> mon_local_set && mon_addr == $past(mem_addr) && mon_size == $past(mem_size))
		else $error("local monitor not armed");
	global_mark_a: assert property (excl_ack_s |=> mon_global_mark == $past(mem_shareable))
		else $error("global mark does not follow shareable");
	plain_mon_a: assert property (ack_s ##0 !mem_excl |=> !mon_local_set && !mon_global_mark)
		else $error("monitor touched by plain load");
	half_ext_a: assert property (ack_s ##0 mem_size == 2'h2 |=> rf_we_target && rf_wdata_target == {16'h0, $past(mem_rdata)})
		else $error("halfword not zero extended");
	byte_ext_a: assert property (ack_s ##0 mem_size == 2'h1 |=> rf_wdata_target == ({16'h0, $past(mem_rdata)} & 32'hff))
		else $error("byte not zero extended");
	excl_nowb_a: assert property (excl_ack_s |=> !rf_we_base)
		else $error("exclusive load wrote base");
	unpred_quiet_a: assert property (unpred_flag |-> done && !rf_we_target && !rf_we_base && !mem_req)
		else $error("unpredictable case had an effect");
	cond_fail_a: assert property (instr_valid && instr_ready && !cond_pass |=> (!mem_req && !rf_we_target) [*2])
		else $error("failed condition still executed");
	busy_ready_a: assert property (mem_req |-> !instr_ready)
		else $error("instruction port open during access");
endmodule : load_check
bind halfword_byte_load_decode load_check u_load_check (.sys_clk, .rst_n, .instr_valid, .instr_ready, .cond_pass,
	.mem_req, .mem_addr, .mem_size, .mem_excl, .mem_ack, .mem_rdata, .mem_shareable, .mon_local_set, .mon_global_mark,
	.mon_addr, .mon_size, .rf_we_target, .rf_wdata_target, .rf_we_base, .done, .unpred_flag);

// *** mem_model.sv ***
// Memory system model answering the load block
`timescale 1ns/1ps
module mem_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_ack,
	output logic [15:0] mem_rdata,
	output logic mem_shareable
);
	logic [2:0] wait_q;
	// Ack after zero or three waits; outside an ack data and attribute keep toggling
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{mem_ack, mem_rdata, mem_shareable, wait_q} <= '0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			mem_shareable <= ~mem_shareable;
			if (mem_req && !mem_ack) begin
				if (wait_q >= (slow ? 3'h3 : 3'h0)) begin
					mem_ack <= 1'b1;
					mem_rdata <= mem_addr[15:0] ^ 16'hc3a5;
					mem_shareable <= mem_addr[4];
					wait_q <= 3'h0;
				end else begin
					wait_q <= wait_q + 3'h1;
				end
			end
		end
	end
endmodule : mem_model

// *** testbench.sv ***
// Self-checking bench for the narrow load block
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0;
	logic instr_wide = 1'b0;
	logic cond_pass = 1'b1;
	logic slow = 1'b0;
	logic [31:0] instr = 32'h0;
	logic [31:0] pc_value = 32'h0;
	logic instr_ready, mem_req, mem_excl, mem_ack, mem_shareable, mon_local_set, mon_global_mark, done;
	logic rf_we_target, rf_we_base, undef_trap, unpred_flag, unpriv_redirect, not_handled;
	logic [3:0] rf_raddr_a, rf_raddr_b, rf_waddr_target, rf_waddr_base, g_tr, g_f, g_bn;
	logic [31:0] mem_addr, mon_addr, rf_wdata_target, rf_wdata_base, g_addr, g_t, g_b;
	logic [1:0] mem_size, mon_size;
	logic [2:0] g_sz;
	logic [15:0] mem_rdata;
	int n_errors = 0;
	int tests_run = 0;
	// Core clock, 4 ns period
	always #2 sys_clk = ~sys_clk;
	// Register file: each register holds a value made from its index
	function automatic logic [31:0] rv(input logic [3:0] i);
		return 32'h20000000 + 32'(i) * 32'h110;
	endfunction : rv
	halfword_byte_load_decode u_halfword_byte_load_decode (.sys_clk, .rst_n, .instr_valid, .instr, .instr_wide,
		.cond_pass, .pc_value, .instr_ready, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a(rv(rf_raddr_a)),
		.rf_rdata_b(rv(rf_raddr_b)), .mem_req, .mem_addr, .mem_size, .mem_excl, .mem_ack, .mem_rdata, .mem_shareable,
		.mon_local_set, .mon_global_mark, .mon_addr, .mon_size, .rf_we_target, .rf_waddr_target, .rf_wdata_target,
		.rf_we_base, .rf_waddr_base, .rf_wdata_base, .done, .undef_trap, .unpred_flag, .unpriv_redirect, .not_handled);
	mem_model u_mem_model (.sys_clk, .rst_n, .slow, .mem_req, .mem_addr, .mem_ack, .mem_rdata, .mem_shareable);
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Offer one instruction, record the block's actions until done
	task automatic issue(input logic [31:0] i, input logic w, input logic c);
		int k;
		{g_addr, g_t, g_b, g_sz, g_tr, g_f, g_bn} = '0;
		for (k = 0; k < 20 && instr_ready !== 1'b1; k++) @(posedge sys_clk) #1;
		if (instr_ready === 1'b1) begin
			@(posedge sys_clk);
			{instr_valid, instr, instr_wide, cond_pass} <= {1'b1, i, w, c};
			@(posedge sys_clk);
			instr_valid <= 1'b0;
			for (k = 0; k < 40; k++) begin
				#1;
				if (mem_req === 1'b1) {g_sz, g_addr} = {mem_excl, mem_size, mem_addr};
				if (rf_we_target === 1'b1) {g_tr, g_t} = {rf_waddr_target, rf_wdata_target};
				if (rf_we_base === 1'b1) {g_bn, g_b} = {rf_waddr_base, rf_wdata_base};
				g_f = g_f | {undef_trap, unpred_flag, unpriv_redirect, not_handled};
				if (done === 1'b1) return;
				@(posedge sys_clk);
			end
		end
		// Ready or done never came: count it and stop
		chk(32'h0, 32'h1);
		final_report();
	endtask : issue
	// Judge a load: address, kind and size, target, zero-extended data, base update
	task automatic ld(input logic [31:0] a, input logic [2:0] s, input logic [3:0] t, input logic [31:0] b);
		logic [15:0] d;
		d = a[15:0] ^ 16'hc3a5;
		chk(g_addr, a);
		chk(32'({g_f, g_sz, g_tr}), 32'({4'h0, s, t}));
		chk(g_t, s[1:0] == 2'h1 ? {24'h0, d[7:0]} : {16'h0, d});
		chk(g_b, b);
	endtask : ld
	// Judge an instruction that must leave no effect, only its flags
	task automatic nx(input logic [31:0] i, input logic w, input logic c, input logic [3:0] f);
		issue(i, w, c);
		chk(g_addr | g_t | g_b, 32'h0);
		chk(32'(g_f), 32'(f));
	endtask : nx
	task automatic t_excl();
		@(posedge sys_clk) slow <= 1'b1;
		issue(32'he8d37f4f, 1'b1, 1'b1);
		ld(rv(4'h3), 3'h5, 4'h7, 32'h0);
		@(posedge sys_clk) slow <= 1'b0;
		issue(32'he8d48f5f, 1'b1, 1'b1);
		ld(rv(4'h4), 3'h6, 4'h8, 32'h0);
		$display("exclusive loads done");
	endtask : t_excl
	task automatic t_offs();
		issue(32'h8fca, 1'b0, 1'b1);
		ld(rv(4'h1) + 32'd62, 3'h2, 4'h2, 32'h0);
		issue(32'hf8b67fff, 1'b1, 1'b1);
		ld(rv(4'h6) + 32'd4095, 3'h2, 4'h7, 32'h0);
		issue(32'hf8352dff, 1'b1, 1'b1);
		ld(rv(4'h5) - 32'd255, 3'h2, 4'h2, rv(4'h5) - 32'd255);
		chk(32'(g_bn), 32'h5);
		issue(32'hf8352b10, 1'b1, 1'b1);
		ld(rv(4'h5), 3'h2, 4'h2, rv(4'h5) + 32'h10);
		chk(32'(g_bn), 32'h5);
		issue(32'hf8352c01, 1'b1, 1'b1);
		ld(rv(4'h5) - 32'h1, 3'h2, 4'h2, 32'h0);
		$display("offset forms done");
	endtask : t_offs
	task automatic t_reg_lit();
		issue(32'h5a53, 1'b0, 1'b1);
		ld(rv(4'h2) + rv(4'h1), 3'h2, 4'h3, 32'h0);
		@(posedge sys_clk) slow <= 1'b1;
		issue(32'hf8323034, 1'b1, 1'b1);
		ld(rv(4'h2) + (rv(4'h4) << 3), 3'h2, 4'h3, 32'h0);
		@(posedge sys_clk) slow <= 1'b0;
		pc_value <= 32'h1002;
		issue(32'hf8bf1123, 1'b1, 1'b1);
		ld(32'h1123, 3'h2, 4'h1, 32'h0);
		issue(32'hf83f1fff, 1'b1, 1'b1);
		ld(32'h1, 3'h2, 4'h1, 32'h0);
		$display("register and literal forms done");
	endtask : t_reg_lit
	task automatic t_quiet();
		nx(32'hf8352a08, 1'b1, 1'b1, 4'h8);
		nx(32'hf8352e08, 1'b1, 1'b1, 4'h2);
		nx(32'hf835fc08, 1'b1, 1'b1, 4'h0);
		nx(32'hf8b5f123, 1'b1, 1'b1, 4'h0);
		nx(32'he8d3df4f, 1'b1, 1'b1, 4'h4);
		nx(32'he8df2f5f, 1'b1, 1'b1, 4'h4);
		nx(32'hf8355d04, 1'b1, 1'b1, 4'h4);
		nx(32'hf835fd04, 1'b1, 1'b1, 4'h4);
		nx(32'hf835dc04, 1'b1, 1'b1, 4'h4);
		nx(32'hf8b5d001, 1'b1, 1'b1, 4'h4);
		nx(32'hf832303f, 1'b1, 1'b1, 4'h4);
		nx(32'hf832d034, 1'b1, 1'b1, 4'h4);
		nx(32'hf832f034, 1'b1, 1'b1, 4'h0);
		nx(32'hf8b67fff, 1'b1, 1'b0, 4'h0);
		nx(32'h0, 1'b0, 1'b1, 4'h1);
		$display("non-executing cases done");
	endtask : t_quiet
	// Reset for five cycles, then run every scenario
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_excl();
		t_offs();
		t_reg_lit();
		t_quiet();
		final_report();
	end
endmodule : testbench
